// file: verilog/tvpc_ctrl.sv
// vbus, vconn and discharge protection controller for one type-c port
// ==========================================================
// How it works
// R1: the two vconn switches are never on together, with a dead cycle on swap.
// R2: any of the three reverse-current flags turns the provider switch off.
// R3: reverse current lasting 10 us latches a fault and holds the gate off.
// R4: reverse current is recognised only while the provider switch is on.
// R5: a reverse-current flag opens the provider switch well within 1 us.
// R6: over-temperature opens the load switch, which recloses when it cools.
// R7: after a detach the discharge path runs until vbus is below 0.8 V.
// R8: the two cc comparators give attach, detach, line activity and range.
// R9: the first flag is the sense-resistor drop, negative above positive.
// R10: the second flag is connector vbus above the negative sense input.
// R11: flag three sees a divided negative input, 33.33 or 25 % by software.
// R12: overcurrent and under/overvoltage thresholds are software registers.
// R13: overvoltage, overcurrent, short circuit open the switch, latch flags.
// R14: every analog input is synchronised and filters count system clocks.
module tvpc_ctrl
  import tvpc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // register bus
  input wire logic [tvpc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [tvpc_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [tvpc_pkg::DATA_W-1:0] reg_rdata_out,
  // interrupt
  output logic irq_out,
  // reverse-current comparators
  input wire logic revcur_sense_resistor_flag_in,
  input wire logic revcur_switch_drop_flag_in,
  input wire logic revcur_max_level_flag_in,
  // protection detectors and sensors
  input wire logic overvoltage_protect_in,
  input wire logic overcurrent_protect_in,
  input wire logic short_circuit_protect_in,
  input wire logic under_over_voltage_detect_uv_in,
  input wire logic over_temp_in,
  input wire logic vbus_below_safe_in,
  input wire logic vconn_overcurrent_in,
  // configuration-channel comparators
  input wire logic cc_comp_low_in,
  input wire logic cc_comp_high_in,
  // switch and discharge drives
  output logic vbus_switch_out,
  output logic vconn_cc1_out,
  output logic vconn_cc2_out,
  output logic vbus_discharge_out,
  output logic cc_sense_sel_out,
  // analog thresholds and options
  output logic [tvpc_pkg::TH_W-1:0] ocp_threshold_out,
  output logic [tvpc_pkg::TH_W-1:0] ov_threshold_out,
  output logic [tvpc_pkg::TH_W-1:0] uv_threshold_out,
  output logic [tvpc_pkg::TH_W-1:0] rcp_vref_out,
  output logic rcp_div_25pct_out
);
  import tvpc_pkg::*;

  localparam int FAST_MAX = RCP_FAST_CYC;

  typedef struct packed
  {
    tvpc_vbus_state_type vbus_state;
    logic [CNT_W-1:0] rcp_cnt;
    logic rcp_armed;
    logic [CNT_W-1:0] cc_cnt;
    logic [1:0] cc_cand;
    logic [1:0] cc_range;
    logic attached;
    logic discharge;
    logic vconn1;
    logic vconn2;
    logic vbus_sw;
    logic [SYN_N-1:0] syn_prev;
    logic [EV_N-1:0] events;
  } tvpc_ctrl_state_type;

  tvpc_ctrl_state_type st_r;
  tvpc_ctrl_state_type st_nxt;

  logic [SYN_N-1:0] raw;
  logic [SYN_N-1:0] syn;
  logic rcp_any;
  logic hard_fault;
  logic [1:0] cc_raw;
  logic vbus_en;
  logic vconn_en;
  logic cc_sel;
  logic want1;
  logic want2;

  tvpc_reg_if rif ();

  // ==========================================================
  // input synchroniser
  assign raw[SYN_REVCUR_SENSE_RESISTOR_FLAG] = revcur_sense_resistor_flag_in;
  assign raw[SYN_REVCUR_SWITCH_DROP_FLAG] = revcur_switch_drop_flag_in;
  assign raw[SYN_REVCUR_MAX_LEVEL_FLAG] = revcur_max_level_flag_in;
  assign raw[SYN_OVP] = overvoltage_protect_in;
  assign raw[SYN_OCP] = overcurrent_protect_in;
  assign raw[SYN_SCP] = short_circuit_protect_in;
  assign raw[SYN_UV] = under_over_voltage_detect_uv_in;
  assign raw[SYN_THERM] = over_temp_in;
  assign raw[SYN_VLOW] = vbus_below_safe_in;
  assign raw[SYN_CCLO] = cc_comp_low_in;
  assign raw[SYN_CCHI] = cc_comp_high_in;
  assign raw[SYN_VCONN_OC] = vconn_overcurrent_in;

  // no logic reads a raw comparator level directly
  tvpc_sync u_sync // [R14]
  (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .raw_in (raw),
    .synced_out (syn)
  );

  // ==========================================================
  // register file
  tvpc_regs u_regs
  (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .addr_in (reg_addr_in),
    .wdata_in (reg_wdata_in),
    .write_in (reg_write_in),
    .read_in (reg_read_in),
    .rdata_out (reg_rdata_out),
    .irq_out (irq_out),
    .rif (rif.regs)
  );

  assign vbus_en = rif.ctrl[CTRL_VBUS_EN];
  assign vconn_en = rif.ctrl[CTRL_VCONN_EN];
  assign cc_sel = rif.ctrl[CTRL_CC_SEL];

  // ==========================================================
  // derived conditions
  // the three comparators carry their own analog thresholds; here they merge
  assign rcp_any = syn[SYN_REVCUR_SENSE_RESISTOR_FLAG] | syn[SYN_REVCUR_SWITCH_DROP_FLAG] |
                   syn[SYN_REVCUR_MAX_LEVEL_FLAG]; // [R2] [R9] [R10] [R11]
  assign hard_fault = syn[SYN_OVP] | syn[SYN_OCP] | syn[SYN_SCP];
  // comparators sit on the sensed line; high above open, low above rd floor
  assign cc_raw = syn[SYN_CCHI] ? CC_RANGE_OPEN :
                  (syn[SYN_CCLO] ? CC_RANGE_RD : CC_RANGE_RA); // [R8]
  // vconn feeds the line that is not being sensed
  assign want1 = vconn_en && cc_sel && st_r.attached && !syn[SYN_VCONN_OC];
  assign want2 = vconn_en && !cc_sel && st_r.attached &&
                 !syn[SYN_VCONN_OC];

  // ==========================================================
  // next-state logic
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.events = EV_NONE;
    st_nxt.syn_prev = syn;

    // cc debounce; any change of range counts as line activity
    if (cc_raw != st_r.cc_cand)
    begin
      st_nxt.cc_cand = cc_raw;
      st_nxt.cc_cnt = CNT_ZERO;
      st_nxt.events[EV_ACTIVITY] = 1'b1; // [R8]
    end
    else if (st_r.cc_cnt < CC_LAST)
    begin
      st_nxt.cc_cnt = st_r.cc_cnt + CNT_ONE; // [R14]
    end
    else
    begin
      st_nxt.cc_range = st_r.cc_cand;
    end
    st_nxt.attached = (st_nxt.cc_range == CC_RANGE_RD); // [R8]
    st_nxt.events[EV_ATTACH] = st_nxt.attached && !st_r.attached; // [R8]
    st_nxt.events[EV_DETACH] = !st_nxt.attached && st_r.attached; // [R8]

    // fault edges for the status register
    st_nxt.events[EV_OVP] = syn[SYN_OVP] && !st_r.syn_prev[SYN_OVP];
    st_nxt.events[EV_OCP] = syn[SYN_OCP] && !st_r.syn_prev[SYN_OCP];
    st_nxt.events[EV_SCP] = syn[SYN_SCP] && !st_r.syn_prev[SYN_SCP];
    st_nxt.events[EV_THERM] = syn[SYN_THERM] && !st_r.syn_prev[SYN_THERM];

    // arming only from the on state; persistence keeps counting after
    // the fast trip so a sustained reverse current still latches
    if (!rcp_any)
    begin
      st_nxt.rcp_armed = 1'b0;
      st_nxt.rcp_cnt = CNT_ZERO;
    end
    else if (st_r.vbus_state == VS_ON)
    begin
      st_nxt.rcp_armed = 1'b1; // [R4]
    end
    if (rcp_any && st_r.rcp_armed && st_r.rcp_cnt < RCP_LAST)
    begin
      st_nxt.rcp_cnt = st_r.rcp_cnt + CNT_ONE; // [R14]
    end

    // provider switch state machine
    case (st_r.vbus_state)
      VS_OFF:
      begin
        if (vbus_en && st_r.attached && !syn[SYN_THERM] && !hard_fault &&
            !rcp_any)
        begin
          st_nxt.vbus_state = VS_ON; // [R6]
        end
      end
      VS_ON:
      begin
        if (hard_fault)
        begin
          st_nxt.vbus_state = VS_FAULT; // [R13]
        end
        else if (rcp_any || syn[SYN_THERM] || !vbus_en || !st_r.attached)
        begin
          st_nxt.vbus_state = VS_OFF; // [R2] [R5] [R6]
        end
      end
      VS_FAULT:
      begin
        // software clears the lockout by dropping the enable
        if (!vbus_en)
        begin
          st_nxt.vbus_state = VS_OFF;
        end
      end
      default: st_nxt.vbus_state = VS_OFF;
    endcase
    if (st_r.rcp_armed && rcp_any && st_r.rcp_cnt == RCP_LAST)
    begin
      st_nxt.vbus_state = VS_FAULT; // [R3]
      st_nxt.rcp_armed = 1'b0;
      st_nxt.rcp_cnt = CNT_ZERO;
      st_nxt.events[EV_RCP] = 1'b1; // [R3]
    end
    st_nxt.vbus_sw = (st_nxt.vbus_state == VS_ON);

    // discharge from detach until the floating vbus is safe
    if (st_nxt.events[EV_DETACH] && rif.ctrl[CTRL_DISCH_EN])
    begin
      st_nxt.discharge = 1'b1; // [R7]
    end
    else if (syn[SYN_VLOW] || st_nxt.vbus_sw)
    begin
      st_nxt.discharge = 1'b0; // [R7]
    end

    // break before make: a swap passes through both off
    st_nxt.vconn1 = want1 && !st_r.vconn2; // [R1]
    st_nxt.vconn2 = want2 && !st_r.vconn1; // [R1]
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      st_r <= '{vbus_state: VS_OFF, rcp_cnt: CNT_ZERO, rcp_armed: 1'b0,
                cc_cnt: CNT_ZERO, cc_cand: CC_RANGE_RA,
                cc_range: CC_RANGE_RA, attached: 1'b0, discharge: 1'b0,
                vconn1: 1'b0, vconn2: 1'b0, vbus_sw: 1'b0,
                syn_prev: SYN_ZERO, events: EV_NONE};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs and register-side views
  assign vbus_switch_out = st_r.vbus_sw;
  assign vconn_cc1_out = st_r.vconn1;
  assign vconn_cc2_out = st_r.vconn2;
  assign vbus_discharge_out = st_r.discharge;
  assign cc_sense_sel_out = rif.ctrl[CTRL_CC_SEL];
  assign ocp_threshold_out = rif.thresh[TH_OCP_LSB +: TH_W]; // [R12]
  assign ov_threshold_out = rif.thresh[TH_OV_LSB +: TH_W]; // [R12]
  assign uv_threshold_out = rif.thresh[TH_UV_LSB +: TH_W]; // [R12]
  assign rcp_vref_out = rif.thresh[TH_VREF_LSB +: TH_W]; // [R11]
  assign rcp_div_25pct_out = rif.ctrl[CTRL_DIV_25]; // [R11]
  assign rif.events = st_r.events;
  assign rif.live[ST_VBUS] = st_r.vbus_sw;
  assign rif.live[ST_VCONN1] = st_r.vconn1;
  assign rif.live[ST_VCONN2] = st_r.vconn2;
  assign rif.live[ST_DISCH] = st_r.discharge;
  assign rif.live[ST_ATTACHED] = st_r.attached;
  assign rif.live[ST_UV] = syn[SYN_UV];
  assign rif.live[ST_RANGE_LSB +: 2] = st_r.cc_range;
  assign rif.live[ST_FAULT] = (st_r.vbus_state == VS_FAULT);

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  chk_vconn_one_only: assert property ( // [R1]
    !(vconn_cc1_out && vconn_cc2_out))
    else $error("both vconn switches on");

  chk_rcp_fast_off: assert property ( // [R2] [R5]
    (vbus_switch_out && rcp_any) |-> ##[1:FAST_MAX] !vbus_switch_out)
    else $error("switch not opened on reverse current");

  chk_rcp_persist_time: assert property ( // [R3]
    st_r.events[EV_RCP] |-> $past(st_r.rcp_cnt) == RCP_LAST)
    else $error("reverse-current fault before persistence");

  chk_rcp_arm_on: assert property ( // [R4]
    $rose(st_r.rcp_armed) |-> $past(st_r.vbus_state) == VS_ON)
    else $error("reverse current armed with switch off");

  chk_therm_off: assert property ( // [R6]
    syn[SYN_THERM] |=> !vbus_switch_out)
    else $error("switch on while hot");

  chk_disch_hold: assert property ( // [R7]
    (vbus_discharge_out && !syn[SYN_VLOW] && !st_nxt.vbus_sw)
    |=> vbus_discharge_out)
    else $error("discharge ended early");

  chk_attach_range: assert property ( // [R8] [R14]
    $rose(st_r.attached) |->
    ($past(st_r.cc_cnt) == CC_LAST) && (st_r.cc_range == CC_RANGE_RD))
    else $error("attach without a debounced rd range");

  chk_fault_gate_off: assert property ( // [R13]
    (hard_fault && vbus_switch_out) |=> !vbus_switch_out ##1 !vbus_switch_out)
    else $error("switch on during hard fault");

  chk_fault_lockout: assert property ( // [R3] [R13]
    (st_r.vbus_state == VS_FAULT && vbus_en) |=> !vbus_switch_out)
    else $error("lockout left while enabled");

  cov_rcp_fault: cover property (st_r.events[EV_RCP]);
  cov_attach_on: cover property ($rose(vbus_switch_out));
  cov_discharge_done: cover property ($fell(vbus_discharge_out));
  cov_vconn_swap: cover property (vconn_cc1_out ##[1:8] vconn_cc2_out);

endmodule : tvpc_ctrl

// file: verilog/tvpc_pkg.sv
// constants, register map and types of the vbus protection controller
package tvpc_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_NS = 25;
  localparam int RCP_PERSIST_NS = 10000;
  localparam int RCP_PERSIST_CYC = (RCP_PERSIST_NS + CLK_NS - 1) / CLK_NS;
  localparam int RCP_FAST_NS = 1000;
  localparam int RCP_FAST_CYC = RCP_FAST_NS / CLK_NS;
  localparam int CC_DEBOUNCE_NS = 10000;
  localparam int CC_DEBOUNCE_CYC = (CC_DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] RCP_LAST = CNT_W'(RCP_PERSIST_CYC - 1);
  localparam logic [CNT_W-1:0] CC_LAST = CNT_W'(CC_DEBOUNCE_CYC - 1);

  // ==========================================================
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_THRESH = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h10;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // control register bits
  localparam int CTRL_VBUS_EN = 0;
  localparam int CTRL_VCONN_EN = 1;
  localparam int CTRL_CC_SEL = 2;
  localparam int CTRL_DIV_25 = 3;
  localparam int CTRL_DISCH_EN = 4;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h10;

  // threshold register fields, one byte each
  localparam int TH_W = 8;
  localparam int TH_OCP_LSB = 0;
  localparam int TH_OV_LSB = 8;
  localparam int TH_UV_LSB = 16;
  localparam int TH_VREF_LSB = 24;
  localparam logic [DATA_W-1:0] THRESH_RST = 32'h8080_8080;

  // event bits, same layout in status and mask
  localparam int EV_RCP = 0;
  localparam int EV_OVP = 1;
  localparam int EV_OCP = 2;
  localparam int EV_SCP = 3;
  localparam int EV_THERM = 4;
  localparam int EV_ATTACH = 5;
  localparam int EV_DETACH = 6;
  localparam int EV_ACTIVITY = 7;
  localparam int EV_N = 8;
  localparam logic [EV_N-1:0] EV_NONE = 8'h00;

  // live state register fields
  localparam int ST_VBUS = 0;
  localparam int ST_VCONN1 = 1;
  localparam int ST_VCONN2 = 2;
  localparam int ST_DISCH = 3;
  localparam int ST_ATTACHED = 4;
  localparam int ST_UV = 5;
  localparam int ST_RANGE_LSB = 6;
  localparam int ST_FAULT = 8;
  localparam int ST_W = 9;

  // synchronised input vector
  localparam int SYN_REVCUR_SENSE_RESISTOR_FLAG = 0;
  localparam int SYN_REVCUR_SWITCH_DROP_FLAG = 1;
  localparam int SYN_REVCUR_MAX_LEVEL_FLAG = 2;
  localparam int SYN_OVP = 3;
  localparam int SYN_OCP = 4;
  localparam int SYN_SCP = 5;
  localparam int SYN_UV = 6;
  localparam int SYN_THERM = 7;
  localparam int SYN_VLOW = 8;
  localparam int SYN_CCLO = 9;
  localparam int SYN_CCHI = 10;
  localparam int SYN_VCONN_OC = 11;
  localparam int SYN_N = 12;
  localparam logic [SYN_N-1:0] SYN_ZERO = 12'h000;

  // voltage range on the sensed configuration-channel line
  localparam logic [1:0] CC_RANGE_RA = 2'h0;
  localparam logic [1:0] CC_RANGE_RD = 2'h1;
  localparam logic [1:0] CC_RANGE_OPEN = 2'h2;

  // provider switch states
  typedef enum logic [2:0]
  {
    VS_OFF = 3'b001,
    VS_ON = 3'b010,
    VS_FAULT = 3'b100
  } tvpc_vbus_state_type;

endpackage : tvpc_pkg

// file: verilog/tvpc_reg_if.sv
// carrier between the protection core and its register file
interface tvpc_reg_if;
  import tvpc_pkg::*;

  // ==========================================================
  // control and thresholds from software
  logic [CTRL_W-1:0] ctrl;
  logic [DATA_W-1:0] thresh;
  // events and live state from the core
  logic [EV_N-1:0] events;
  logic [ST_W-1:0] live;

  modport regs (output ctrl, output thresh, input events, input live);
  modport core (input ctrl, input thresh, output events, output live);

endinterface : tvpc_reg_if

// file: verilog/tvpc_sync.sv
// two-stage synchroniser for all comparator and sensor inputs
module tvpc_sync
  import tvpc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // raw and synchronised levels
  input wire logic [SYN_N-1:0] raw_in,
  output logic [SYN_N-1:0] synced_out
);
  import tvpc_pkg::*;

  typedef struct packed
  {
    logic [SYN_N-1:0] stage1;
    logic [SYN_N-1:0] stage2;
  } tvpc_sync_state_type;

  tvpc_sync_state_type st_r;
  tvpc_sync_state_type st_nxt;

  // ==========================================================
  // first stage feeds only the second stage
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.stage1 = raw_in;
    st_nxt.stage2 = st_r.stage1;
  end

  // state register
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      st_r <= '{stage1: SYN_ZERO, stage2: SYN_ZERO};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign synced_out = st_r.stage2;

endmodule : tvpc_sync

// file: verilog/tvpc_regs.sv
// register file: control, thresholds, sticky status, mask, live state
module tvpc_regs
  import tvpc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // register bus
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [DATA_W-1:0] rdata_out,
  // interrupt
  output logic irq_out,
  // core side
  tvpc_reg_if.regs rif
);
  import tvpc_pkg::*;

  typedef struct packed
  {
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] thresh;
    logic [EV_N-1:0] status;
    logic [EV_N-1:0] mask;
    logic [DATA_W-1:0] rdata;
    logic irq;
  } tvpc_regs_state_type;

  tvpc_regs_state_type st_r;
  tvpc_regs_state_type st_nxt;

  // ==========================================================
  // decode, read mux, sticky status with set winning over clear
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = DATA_ZERO;
    if (write_in)
    begin
      case (addr_in)
        REG_CTRL: st_nxt.ctrl = wdata_in[CTRL_W-1:0];
        REG_THRESH: st_nxt.thresh = wdata_in; // [R12]
        REG_MASK: st_nxt.mask = wdata_in[EV_N-1:0];
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    if (read_in)
    begin
      case (addr_in)
        REG_CTRL: st_nxt.rdata = {{(DATA_W-CTRL_W){1'b0}}, st_r.ctrl};
        REG_THRESH: st_nxt.rdata = st_r.thresh;
        REG_STATUS: st_nxt.rdata = {{(DATA_W-EV_N){1'b0}}, st_r.status};
        REG_MASK: st_nxt.rdata = {{(DATA_W-EV_N){1'b0}}, st_r.mask};
        REG_STATE: st_nxt.rdata = {{(DATA_W-ST_W){1'b0}}, rif.live};
        default: st_nxt.rdata = DATA_ZERO; // unmapped reads as zero
      endcase
    end
    // read of status clears it; a fresh event in that cycle survives
    if (read_in && addr_in == REG_STATUS)
    begin
      st_nxt.status = rif.events; // [R13]
    end
    else
    begin
      st_nxt.status = st_r.status | rif.events; // [R13]
    end
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  // state register
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      st_r <= '{ctrl: CTRL_RST, thresh: THRESH_RST, status: EV_NONE,
                mask: EV_NONE, rdata: DATA_ZERO, irq: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign irq_out = st_r.irq;
  assign rif.ctrl = st_r.ctrl;
  assign rif.thresh = st_r.thresh;

  // ==========================================================
  // checks
  chk_thresh_write: assert property ( // [R12]
    @(posedge clock_in) disable iff (reset_in)
    (write_in && addr_in == REG_THRESH) |=> (rif.thresh == $past(wdata_in)))
    else $error("threshold write not taken");

  chk_status_sticky: assert property ( // [R13]
    @(posedge clock_in) disable iff (reset_in)
    (|rif.events) |=>
    ((st_r.status & $past(rif.events)) == $past(rif.events)))
    else $error("event lost from status");

endmodule : tvpc_regs

// file: dv/tvpc_far_model.sv
// behavioural far side: vbus rail, cc comparators, reverse-current sensors
module tvpc_far_model
(
  // controller drives
  input wire logic clock_in,
  input wire logic vbus_switch_in,
  input wire logic vbus_discharge_in,
  // scenario commands
  input wire logic sink_attached_in,
  input wire logic [2:0] back_feed_in,
  // comparator outputs
  output logic cc_comp_low_out,
  output logic cc_comp_high_out,
  output logic [2:0] revcur_flags_out,
  output logic vbus_below_safe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] rail_r = 6'h00;
  // ==========================================================
  // rail: 0x32 counts = 5 V; a floating rail only falls by discharge
  always @(posedge clock_in)
  begin
    if (vbus_switch_in)
      rail_r <= 6'h32;
    else if (vbus_discharge_in && rail_r != 6'h00)
      rail_r <= rail_r - 6'h01;
  end
  assign vbus_below_safe_out = (rail_r < 6'h08); // 0.8 V
  // an Rd sink sits between the floor and the open level
  assign cc_comp_low_out = sink_attached_in;
  assign cc_comp_high_out = !sink_attached_in;
  // one sensor per path: resistor drop, switch drop, divided level
  assign revcur_flags_out = back_feed_in;
endmodule : tvpc_far_model

// file: dv/tb_top.sv
// self-checking bench for the vbus protection controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tvpc_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [2:0] feed = 3'h0;
  logic [2:0] fault = 3'h0;
  logic hot = 1'b0;
  logic attach = 1'b0;
  logic [1:0] aux = 2'h0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] th_val;
  logic [TH_W-1:0] t0, t1, t2, t3;
  logic [2:0] flags;
  logic irq, sw, vc1, vc2, disch, sel, div25, cc_lo, cc_hi, safe;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] msk_q[$];
  int bad_count = 0;
  int checked = 0;

  // ==========================================================
  // design and far side
  tvpc_ctrl i_dut (.clock_in(clock), .reset_in(reset),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
    .reg_read_in(rd), .reg_rdata_out(rdata), .irq_out(irq),
    .revcur_sense_resistor_flag_in(flags[0]),
    .revcur_switch_drop_flag_in(flags[1]),
    .revcur_max_level_flag_in(flags[2]),
    .overvoltage_protect_in(fault[0]), .overcurrent_protect_in(fault[1]),
    .short_circuit_protect_in(fault[2]),
    .under_over_voltage_detect_uv_in(aux[0]), .over_temp_in(hot),
    .vbus_below_safe_in(safe), .vconn_overcurrent_in(aux[1]),
    .cc_comp_low_in(cc_lo), .cc_comp_high_in(cc_hi),
    .vbus_switch_out(sw), .vconn_cc1_out(vc1), .vconn_cc2_out(vc2),
    .vbus_discharge_out(disch), .cc_sense_sel_out(sel),
    .ocp_threshold_out(t0), .ov_threshold_out(t1),
    .uv_threshold_out(t2), .rcp_vref_out(t3), .rcp_div_25pct_out(div25));
  tvpc_far_model i_far (.clock_in(clock), .vbus_switch_in(sw),
    .vbus_discharge_in(disch), .sink_attached_in(attach),
    .back_feed_in(feed), .cc_comp_low_out(cc_lo), .cc_comp_high_out(cc_hi),
    .revcur_flags_out(flags), .vbus_below_safe_out(safe));

  initial
  begin
    forever #12.5 clock = ~clock;
  end

  // ==========================================================
  // closing, comparisons and bus cycles
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic compare_word(string what, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : compare_word

  task automatic compare_bit(string what, logic e, logic g);
    compare_word(what, 32'(e), 32'(g));
  endtask : compare_bit

  // pins are read in the edge's active region, so they are settled values
  task automatic cycles(int n);
    repeat (n) @(posedge clock);
  endtask : cycles

  task automatic bus_write(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : bus_write

  task automatic bus_read(logic [ADDR_W-1:0] a, logic [31:0] e,
    logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask : bus_read

  // read data stand only in the cycle after the strobe
  always @(posedge clock)
  begin
    rd_d <= rd;
    if (rd_d)
      compare_word("read data", exp_q.pop_front(), rdata & msk_q.pop_front());
    if (!reset)
      compare_bit("vconn both", 1'b0, vc1 & vc2);
  end

  // hang guard, far above the roughly 1550 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    tally_and_finish();
  end

  // ==========================================================
  // scenarios
  initial
  begin
    void'($urandom(48));
    cycles(16);
    reset <= 1'b0;
    compare_word("thresholds", THRESH_RST, {t3, t2, t1, t0});
    bus_read(REG_CTRL, 32'h10, 32'h1F);
    bus_read(8'h40, 32'h0, 32'hFFFF_FFFF);
    bus_write(REG_MASK, 32'h20);
    attach <= 1'b1;
    cycles(420);
    compare_bit("irq", 1'b1, irq);
    bus_read(REG_STATUS, 32'h20, 32'h21);
    bus_read(REG_STATE, 32'h50, 32'h1D0);
    cycles(2);
    compare_bit("irq cleared", 1'b0, irq);
    bus_write(REG_CTRL, 32'h03);
    cycles(4);
    compare_word("switches", 32'h5, {sw, vc1, vc2});
    bus_write(REG_CTRL, 32'h07);
    cycles(4);
    compare_word("switches", 32'hC, {sw, vc1, vc2, div25});
    // vconn overcurrent and undervoltage: vconn drops, state shows vconn off and undervoltage
    aux <= 2'h3;
    cycles(4);
    compare_word("vconn oc", 32'h8, {sw, vc1, vc2, div25});
    bus_read(REG_STATE, 32'h21, 32'h27);
    aux <= 2'h0;
    // short back-feed on each sensor alone: fast open, then reclose
    for (int i = 0; i < 3; i++)
    begin
      feed <= 3'(1 << i);
      cycles(4);
      compare_bit("rcp open", 1'b0, sw);
      feed <= 3'h0;
      cycles(7);
      compare_bit("rcp reclose", 1'b1, sw);
    end
    // persistent back-feed latches, only software releases it
    feed <= 3'h2;
    cycles(420);
    feed <= 3'h0;
    cycles(10);
    compare_bit("rcp lockout", 1'b0, sw);
    bus_read(REG_STATUS, 32'h01, 32'h01);
    bus_write(REG_CTRL, 32'h06);
    bus_write(REG_CTRL, 32'h07);
    cycles(4);
    compare_bit("released", 1'b1, sw);
    hot <= 1'b1;
    cycles(50);
    compare_bit("hot open", 1'b0, sw);
    hot <= 1'b0;
    cycles(5);
    compare_bit("cool reclose", 1'b1, sw);
    for (int i = 0; i < 3; i++)
    begin
      fault <= 3'(1 << i);
      cycles(4);
      fault <= 3'h0;
      cycles(6);
      compare_bit("fault open", 1'b0, sw);
      bus_read(REG_STATUS, 32'(2 << i), 32'(2 << i));
      bus_write(REG_CTRL, 32'h06);
      bus_write(REG_CTRL, 32'h07);
      cycles(4);
      compare_bit("fault release", 1'b1, sw);
    end
    th_val = $urandom();
    bus_write(REG_THRESH, th_val);
    bus_write(REG_CTRL, 32'h0F);
    cycles(2);
    compare_word("thresholds", th_val, {t3, t2, t1, t0});
    compare_bit("divider", 1'b1, div25);
    compare_bit("sense select", 1'b1, sel);
    bus_read(REG_THRESH, th_val, 32'hFFFF_FFFF);
    // detach with a charged rail: discharge until below 0.8 V
    bus_write(REG_CTRL, 32'h11);
    attach <= 1'b0;
    cycles(420);
    compare_word("discharging", 32'h1, {sw, disch});
    cycles(60);
    compare_word("discharged", 32'h1, {disch, safe});
    bus_read(REG_STATUS, 32'h40, 32'h40);
    cycles(3);
    tally_and_finish();
  end
endmodule : tb_top
